// [tpfc_frame_gen.sv]
// Frame clock generator running on the link clock
`timescale 1ns/1ps
module tpfc_frame_gen
   import tpfc_pkg::*;
(
   input wire logic lclk,
   input wire logic rst,
   tpfc_frame_if.gen fif
);

   logic rst_s1, rst_s2;
   logic tog_s1, tog_s2, tog_s3;
   logic div_s1, div_s2;
   logic str_s1, str_s2;
   logic phase_reg;
   logic [FRAME_LEN_W-1:0] cyc_reg;
   logic [FRAME_LEN_W-1:0] len_reg;
   logic evt;
   logic span_two;

   // Reset and control crossings
   always_ff @(posedge lclk) begin
      rst_s1 <= rst;
      rst_s2 <= rst_s1;
      tog_s1 <= fif.evt_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      div_s1 <= fif.frame_divide;
      div_s2 <= div_s1;
      str_s1 <= fif.frame_stretch;
      str_s2 <= str_s1;
   end

   assign evt = tog_s3 ^ tog_s2;
   // stretched frame covers both channel samples
   assign span_two = div_s2 | str_s2;

   always_ff @(posedge lclk) begin
      if (rst_s2) begin
         phase_reg <= 1'b0;
         cyc_reg <= '0;
         len_reg <= '0;
      end else if (evt && (!span_two || phase_reg)) begin
         phase_reg <= 1'b0;
         // Saturated count loads the maximum length (all ones) instead of wrapping
         len_reg <= (cyc_reg == '1) ? cyc_reg : FRAME_LEN_W'(cyc_reg + 1'b1);
         cyc_reg <= '0;
      end else begin
         if (evt) begin
            phase_reg <= 1'b1;
         end
         if (cyc_reg != '1) begin
            cyc_reg <= FRAME_LEN_W'(cyc_reg + 1'b1);
         end
      end
   end

   // High for the first half of each frame
   always_ff @(posedge lclk) begin
      if (rst_s2) begin
         fif.frame_clock <= 1'b0;
      end else begin
         fif.frame_clock <= (cyc_reg < (len_reg >> 1));
      end
   end

endmodule

// [tpfc_frame_if.sv]
// Signals between the sample-clock logic and the frame clock generator
`timescale 1ns/1ps
interface tpfc_frame_if;
   logic evt_toggle;
   logic frame_divide;
   logic frame_stretch;
   logic frame_clock;

   modport ctl (
      output evt_toggle,
      output frame_divide,
      output frame_stretch,
      input frame_clock
   );

   modport gen (
      input evt_toggle,
      input frame_divide,
      input frame_stretch,
      output frame_clock
   );
endinterface

// [tpfc_pattern_gen.sv]
// One channel of test pattern substitution at native sample width
`timescale 1ns/1ps
module tpfc_pattern_gen
   import tpfc_pkg::*;
#(
   parameter int W = SAMPLE_W
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [2:0] sel,
   input wire logic [W-1:0] user_pattern_value,
   input wire logic [W-1:0] sample_in,
   input wire logic sample_valid,
   output logic [W-1:0] data_out,
   output logic valid_out
);

   logic [W-1:0] ramp_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         ramp_reg <= '0;
      end else if (sel != TPFC_PAT_RAMP) begin
         // Held at zero so a sample in the first ramp cycle is zero
         ramp_reg <= '0;
      end else if (sample_valid) begin
         ramp_reg <= ramp_reg + user_pattern_value;
      end
   end

   // substitution ahead of the mapper, full width
   always_ff @(posedge mclk) begin
      if (rst) begin
         data_out <= '0;
         valid_out <= 1'b0;
      end else begin
         valid_out <= sample_valid;
         if (sample_valid) begin
            case (sel)
               TPFC_PAT_CONST: data_out <= user_pattern_value;
               TPFC_PAT_RAMP: data_out <= ramp_reg;
               default: data_out <= sample_in;
            endcase
         end
      end
   end

endmodule

// [tpfc_pkg.sv]
// Constants, field layout and pattern codes for the test pattern and frame clock block
// Operation
// - Constant mode outputs 18-bit user value, MSB-aligned
// - User value doubles as ramp step size
// - Channel B select bits 7-5: normal/ramp/constant
// - Channel A select bits 4-2, same encoding
// - Substitution at native width, every output format
// - Source bit 7 picks core or down-conversion
// - Stretch bit 0 spans A and B samples
package tpfc_pkg;

   localparam int SAMPLE_W = 18;
   localparam int REG_W = 8;
   localparam int ADDR_W = 8;

   // Register offsets
   localparam logic [7:0] ADDR_PAT_LOW = 8'h14;
   localparam logic [7:0] ADDR_PAT_MID = 8'h15;
   localparam logic [7:0] ADDR_PAT_SEL = 8'h16;
   localparam logic [7:0] ADDR_FRAME_CLOCK_CTL = 8'h19;
   localparam logic [7:0] ADDR_SWING_CTL = 8'h1a;

   // Field positions
   localparam int SEL_B_LSB = 5;
   localparam int SEL_A_LSB = 2;
   localparam int SEL_W = 3;
   localparam int PAT_HI_W = 2;
   localparam int FRAME_CLOCK_SOURCE_BIT = 7;
   localparam int FRAME_CLOCK_DIVIDE_BIT = 4;
   localparam int FRAME_CLOCK_STRETCH_BIT = 0;
   localparam int SWING_HALF_BIT = 6;

   // Writable bits; the rest are reserved and read as zero
   localparam logic [7:0] FRAME_CLOCK_CTL_MASK = 8'h91;
   localparam logic [7:0] SWING_CTL_MASK = 8'h40;

   // Reset values
   localparam logic [7:0] RST_PAT_LOW = 8'h00;
   localparam logic [7:0] RST_PAT_MID = 8'h00;
   localparam logic [7:0] RST_PAT_SEL = 8'h00;
   localparam logic [7:0] RST_FRAME_CLOCK_CTL = 8'h00;
   localparam logic [7:0] RST_SWING_CTL = 8'h00;

   // Width of the frame period counter on the link clock
   localparam int FRAME_LEN_W = 8;

   typedef enum logic [2:0] {
      TPFC_PAT_NORMAL = 3'h0,
      TPFC_PAT_RAMP = 3'h2,
      TPFC_PAT_CONST = 3'h3
   } tpfc_pat_t;

endpackage

// [tpfc_rx_model.sv]
// Receiver model measuring frame clock high time and period in link cycles
`timescale 1ns/1ps
module tpfc_rx_model (
   input wire logic lclk,
   input wire logic rst,
   input wire logic frame_clock,
   output int hi_len,
   output int per_len
);
   int cnt;
   logic last;
   always_ff @(posedge lclk) begin
      if (rst) begin
         cnt <= 0;
         last <= 1'b0;
         hi_len <= 0;
         per_len <= 0;
      end else begin
         last <= frame_clock;
         cnt <= (frame_clock && !last) ? 1 : cnt + 1;
         if (frame_clock && !last) per_len <= cnt;
         if (!frame_clock && last) hi_len <= cnt;
      end
   end
endmodule

// [tpfc_top.sv]
// Register file, pattern substitution and frame clock source selection
`timescale 1ns/1ps
module tpfc_top
   import tpfc_pkg::*;
#(
   parameter int W = tpfc_pkg::SAMPLE_W
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic lclk,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [tpfc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [tpfc_pkg::REG_W-1:0] reg_wdata,
   output logic [tpfc_pkg::REG_W-1:0] reg_rdata,
   input wire logic [W-1:0] chan_a_in,
   input wire logic [W-1:0] chan_b_in,
   input wire logic sample_valid,
   input wire logic down_conversion_frame,
   output logic [W-1:0] chan_a_out,
   output logic [W-1:0] chan_b_out,
   output logic out_valid,
   output logic frame_clock,
   output logic half_output_current
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [REG_W-1:0] pat_low_reg;
   logic [REG_W-1:0] pat_mid_reg;
   logic [REG_W-1:0] pat_sel_reg;
   logic [REG_W-1:0] frame_clock_ctl_reg;
   logic [REG_W-1:0] swing_ctl_reg;
   logic [REG_W-1:0] rdata_next;
   logic [W-1:0] user_pattern_value;
   logic [SEL_W-1:0] chan_a_pattern_select;
   logic [SEL_W-1:0] chan_b_pattern_select;
   logic frame_clock_source;
   logic frame_clock_divide;
   logic frame_clock_stretch;
   logic evt_toggle_reg;
   logic frame_evt;
   logic div_reg;
   logic stretch_reg;
   logic half_current_reg;
   logic a_valid;
   logic wr_pat_low;
   logic wr_pat_mid;
   logic wr_pat_sel;
   logic wr_frame_clock_ctl;
   logic wr_swing_ctl;

   tpfc_frame_if fif ();

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] offset);
      hit = (addr == offset);
   endfunction

   function automatic logic [REG_W-1:0] masked(input logic [REG_W-1:0] data,
                                              input logic [7:0] mask);
      masked = data & mask;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Register writes

   // One strobe per mapped byte; unmapped writes fall through
   assign wr_pat_low = reg_wr && hit(reg_addr, ADDR_PAT_LOW);
   assign wr_pat_mid = reg_wr && hit(reg_addr, ADDR_PAT_MID);
   assign wr_pat_sel = reg_wr && hit(reg_addr, ADDR_PAT_SEL);
   assign wr_frame_clock_ctl = reg_wr && hit(reg_addr, ADDR_FRAME_CLOCK_CTL);
   assign wr_swing_ctl = reg_wr && hit(reg_addr, ADDR_SWING_CTL);

   always_ff @(posedge mclk) begin
      if (rst) begin
         pat_low_reg <= RST_PAT_LOW;
      end else if (wr_pat_low) begin
         pat_low_reg <= reg_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pat_mid_reg <= RST_PAT_MID;
      end else if (wr_pat_mid) begin
         pat_mid_reg <= reg_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pat_sel_reg <= RST_PAT_SEL;
      end else if (wr_pat_sel) begin
         pat_sel_reg <= reg_wdata;
      end
   end

   // reserved bits dropped, read as zero
   always_ff @(posedge mclk) begin
      if (rst) begin
         frame_clock_ctl_reg <= RST_FRAME_CLOCK_CTL;
      end else if (wr_frame_clock_ctl) begin
         frame_clock_ctl_reg <= masked(reg_wdata, FRAME_CLOCK_CTL_MASK);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         swing_ctl_reg <= RST_SWING_CTL;
      end else if (wr_swing_ctl) begin
         swing_ctl_reg <= masked(reg_wdata, SWING_CTL_MASK);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register reads

   always_comb begin
      rdata_next = '0;
      if (hit(reg_addr, ADDR_PAT_LOW)) begin
         rdata_next = pat_low_reg;
      end else if (hit(reg_addr, ADDR_PAT_MID)) begin
         rdata_next = pat_mid_reg;
      end else if (hit(reg_addr, ADDR_PAT_SEL)) begin
         rdata_next = pat_sel_reg;
      end else if (hit(reg_addr, ADDR_FRAME_CLOCK_CTL)) begin
         rdata_next = frame_clock_ctl_reg;
      end else if (hit(reg_addr, ADDR_SWING_CTL)) begin
         rdata_next = swing_ctl_reg;
      end
   end

   // Read data held until the next read
   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Field decode

   // high bits sit in the select register
   assign user_pattern_value = W'({pat_sel_reg[PAT_HI_W-1:0], pat_mid_reg, pat_low_reg});

   assign chan_b_pattern_select = pat_sel_reg[SEL_B_LSB +: SEL_W];

   assign chan_a_pattern_select = pat_sel_reg[SEL_A_LSB +: SEL_W];

   assign frame_clock_source = frame_clock_ctl_reg[FRAME_CLOCK_SOURCE_BIT];
   assign frame_clock_divide = frame_clock_ctl_reg[FRAME_CLOCK_DIVIDE_BIT];
   assign frame_clock_stretch = frame_clock_ctl_reg[FRAME_CLOCK_STRETCH_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // Pattern substitution per channel

   tpfc_pattern_gen #(
      .W(W)
   ) u_pat_a (
      .mclk(mclk),
      .rst(rst),
      .sel(chan_a_pattern_select),
      .user_pattern_value(user_pattern_value),
      .sample_in(chan_a_in),
      .sample_valid(sample_valid),
      .data_out(chan_a_out),
      .valid_out(a_valid)
   );

   tpfc_pattern_gen #(
      .W(W)
   ) u_pat_b (
      .mclk(mclk),
      .rst(rst),
      .sel(chan_b_pattern_select),
      .user_pattern_value(user_pattern_value),
      .sample_in(chan_b_in),
      .sample_valid(sample_valid),
      .data_out(chan_b_out),
      .valid_out()
   );

   // Both channels share one strobe, so channel A's flop stands for both
   assign out_valid = a_valid;

   ////////////////////////////////////////////////////////////////////////////////
   // Frame clock source and shaping controls

   // core sample strobe or down-conversion frame
   assign frame_evt = frame_clock_source ? down_conversion_frame : sample_valid;

   // One toggle per frame event, crossed into the link domain
   always_ff @(posedge mclk) begin
      if (rst) begin
         evt_toggle_reg <= 1'b0;
      end else if (frame_evt) begin
         evt_toggle_reg <= ~evt_toggle_reg;
      end
   end

   // divide taken as written, software keeps it valid
   always_ff @(posedge mclk) begin
      if (rst) begin
         div_reg <= 1'b0;
      end else begin
         div_reg <= frame_clock_divide;
      end
   end

   // stretch control toward the link domain
   always_ff @(posedge mclk) begin
      if (rst) begin
         stretch_reg <= 1'b0;
      end else begin
         stretch_reg <= frame_clock_stretch;
      end
   end

   assign fif.evt_toggle = evt_toggle_reg;
   assign fif.frame_divide = div_reg;
   assign fif.frame_stretch = stretch_reg;

   tpfc_frame_gen u_frame (
      .lclk(lclk),
      .rst(rst),
      .fif(fif.gen)
   );

   assign frame_clock = fif.frame_clock;

   ////////////////////////////////////////////////////////////////////////////////
   // Output drive strength

   always_ff @(posedge mclk) begin
      if (rst) begin
         half_current_reg <= 1'b0;
      end else begin
         half_current_reg <= swing_ctl_reg[SWING_HALF_BIT];
      end
   end

   assign half_output_current = half_current_reg;

endmodule

// [tpfc_top_asserts.sv]
// Port checker for the test pattern and frame clock block
`timescale 1ns/1ps
module tpfc_top_asserts
   import tpfc_pkg::*;
#(
   parameter int W = SAMPLE_W
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [W-1:0] chan_a_in,
   input wire logic [W-1:0] chan_b_in,
   input wire logic sample_valid,
   input wire logic [W-1:0] chan_a_out,
   input wire logic [W-1:0] chan_b_out,
   input wire logic out_valid
);
   logic [7:0] lo_reg, mid_reg, sel_reg;
   logic a_seen_reg, b_seen_reg;
   logic [W-1:0] user;
   logic [2:0] sa, sb;
   assign user = W'({sel_reg[1:0], mid_reg, lo_reg});
   assign sa = sel_reg[4:2];
   assign sb = sel_reg[7:5];
   ////////////////////////////////////////////////////////////////
   // Shadow of the pattern registers
   always_ff @(posedge mclk) begin
      if (rst) {lo_reg, mid_reg, sel_reg} <= '0;
      else if (reg_wr && reg_addr == ADDR_PAT_LOW) lo_reg <= reg_wdata;
      else if (reg_wr && reg_addr == ADDR_PAT_MID) mid_reg <= reg_wdata;
      else if (reg_wr && reg_addr == ADDR_PAT_SEL) sel_reg <= reg_wdata;
   end
   // Ramp already produced a sample
   always_ff @(posedge mclk) begin
      if (rst || sa != 3'h2) a_seen_reg <= 1'b0;
      else if (sample_valid) a_seen_reg <= 1'b1;
   end
   always_ff @(posedge mclk) begin
      if (rst || sb != 3'h2) b_seen_reg <= 1'b0;
      else if (sample_valid) b_seen_reg <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   AST_VALID_LAT: assert property (sample_valid |=> out_valid)
      else $error("out_valid missing after sample");
   AST_RSVD_ZERO: assert property (reg_rd && reg_addr == ADDR_FRAME_CLOCK_CTL |=>
      (reg_rdata & ~FRAME_CLOCK_CTL_MASK) == 8'h00) else $error("reserved bits read nonzero");
   AST_CONST_A: assert property (sample_valid && sa == 3'h3 |=> chan_a_out == $past(user))
      else $error("chan a constant wrong");
   AST_CONST_B: assert property (sample_valid && sb == 3'h3 |=> chan_b_out == $past(user))
      else $error("chan b constant wrong");
   AST_NORMAL_A: assert property (sample_valid && !(sa inside {3'h2, 3'h3}) |=>
      chan_a_out == $past(chan_a_in)) else $error("chan a normal data wrong");
   AST_NORMAL_B: assert property (sample_valid && !(sb inside {3'h2, 3'h3}) |=>
      chan_b_out == $past(chan_b_in)) else $error("chan b normal data wrong");
   AST_RAMP_START_A: assert property (sample_valid && sa == 3'h2 && !a_seen_reg |=>
      chan_a_out == '0) else $error("chan a ramp not from zero");
   AST_RAMP_STEP_B: assert property (sample_valid && sb == 3'h2 && b_seen_reg |=>
      chan_b_out == W'($past(chan_b_out) + $past(user))) else $error("chan b ramp step wrong");
   cover property (sample_valid && sb == 3'h2 && b_seen_reg);
   cover property (sample_valid && sa == 3'h3);
   cover property (reg_rd && reg_addr == ADDR_FRAME_CLOCK_CTL);
endmodule

bind tpfc_top tpfc_top_asserts #(.W(W)) u_chk (.mclk(mclk), .rst(rst), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .chan_a_in(chan_a_in), .chan_b_in(chan_b_in), .sample_valid(sample_valid),
   .chan_a_out(chan_a_out), .chan_b_out(chan_b_out), .out_valid(out_valid));

// [tpfc_top_bench.sv]
// Self-checking bench for the test pattern and frame clock block
`timescale 1ns/1ps
module tpfc_top_bench;
   import tpfc_pkg::*;
   logic mclk = 0, lclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, sample_valid = 0;
   logic down_conversion_frame = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [17:0] chan_a_in = '0, chan_b_in = '0, chan_a_out, chan_b_out, user, ra, rb;
   logic out_valid, frame_clock, half_output_current;
   logic [2:0] ca, cb;
   int n_errors = 0, tests_run = 0, hi_len, per_len;
   logic [7:0] ad [6] = '{ADDR_PAT_LOW, ADDR_PAT_MID, ADDR_PAT_SEL, ADDR_FRAME_CLOCK_CTL,
      ADDR_SWING_CTL, 8'h17};
   logic [7:0] rb_ff [6] = '{8'hff, 8'hff, 8'hff, 8'h91, 8'h40, 8'h00};
   logic [17:0] st [4] = '{18'h0_0001, 18'h0_0004, 18'h0_0010, 18'h3_ffff};
   logic [7:0] fc [4] = '{8'h00, 8'h80, 8'h01, 8'h10};
   int eh [4] = '{2, 5, 5, 5};
   int ep [4] = '{5, 10, 10, 10};

   always #5 mclk = ~mclk;
   initial begin
      #3.7;
      forever #24 lclk = ~lclk;
   end
   tpfc_top #(.W(SAMPLE_W)) dut (
      .mclk(mclk),
      .rst(rst),
      .lclk(lclk),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .chan_a_in(chan_a_in),
      .chan_b_in(chan_b_in),
      .sample_valid(sample_valid),
      .down_conversion_frame(down_conversion_frame),
      .chan_a_out(chan_a_out),
      .chan_b_out(chan_b_out),
      .out_valid(out_valid),
      .frame_clock(frame_clock),
      .half_output_current(half_output_current)
   );
   tpfc_rx_model rx (
      .lclk(lclk),
      .rst(rst),
      .frame_clock(frame_clock),
      .hi_len(hi_len),
      .per_len(per_len)
   );
   ////////////////////////////////////////////////////////////////
   task automatic tick();
      @(posedge mclk);
      #1;
   endtask
   task automatic fail(string m);
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
   endtask
   task automatic chk_reg(logic [7:0] got, logic [7:0] exp, string m);
      tests_run++;
      if (got !== exp) fail(m);
   endtask
   task automatic chk_smp(logic [17:0] got, logic [17:0] exp, string m);
      tests_run++;
      if (got !== exp) fail(m);
   endtask
   task automatic chk_len(int got, int exp, string m);
      tests_run++;
      if (got != exp) fail(m);
   endtask
   task automatic test_done();
      $display("errors %0d comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = d;
      tick();
      reg_wr = 0;
      tick();
   endtask
   task automatic rdc(logic [7:0] a, logic [7:0] exp, string m);
      reg_rd = 1;
      reg_addr = a;
      tick();
      reg_rd = 0;
      chk_reg(reg_rdata, exp, m);
      tick();
   endtask
   function automatic logic [17:0] f_exp(logic [2:0] s, logic [17:0] d, u, r);
      return s == 3'h3 ? u : s == 3'h2 ? r : d;
   endfunction
   task automatic setp(logic [2:0] a, logic [2:0] b, logic [17:0] u);
      wr(ADDR_PAT_SEL, 8'h00);
      wr(ADDR_PAT_LOW, u[7:0]);
      wr(ADDR_PAT_MID, u[15:8]);
      wr(ADDR_PAT_SEL, {b, a, u[17:16]});
      rdc(ADDR_PAT_SEL, {b, a, u[17:16]}, "select readback");
      ca = a;
      cb = b;
      user = u;
      ra = '0;
      rb = '0;
   endtask
   task automatic smp();
      sample_valid = 1;
      chan_a_in = 18'($urandom);
      chan_b_in = 18'($urandom);
      tick();
      chk_smp(chan_a_out, f_exp(ca, chan_a_in, user, ra), "chan a sample");
      chk_smp(chan_b_out, f_exp(cb, chan_b_in, user, rb), "chan b sample");
      chk_reg(8'(out_valid), 8'h01, "valid after sample");
      if (ca == 3'h2) ra = ra + user;
      if (cb == 3'h2) rb = rb + user;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      #100us;
      fail("timeout");
      test_done();
   end
   initial begin
      void'($urandom(32'hf6b3));
      // Twelve cycles still span the link-side reset sync
      repeat (12) tick();
      rst = 0;
      foreach (ad[i]) rdc(ad[i], 8'h00, "reset value");
      foreach (ad[i]) wr(ad[i], 8'hff);
      foreach (ad[i]) rdc(ad[i], rb_ff[i], "masked readback");
      chk_reg(8'(half_output_current), 8'h01, "swing set");
      wr(ADDR_SWING_CTL, 8'h00);
      chk_reg(8'(half_output_current), 8'h00, "swing clear");
      // All select codes on both channels
      for (int i = 0; i < 8; i++) begin
         setp(3'(i), 3'(7 - i), 18'($urandom));
         repeat (4) smp();
         sample_valid = 0;
         tick();
         chk_reg(8'(out_valid), 8'h00, "valid drops");
      end
      // Documented ramp steps and wrap
      foreach (st[j]) begin
         setp(3'h2, 3'h2, st[j]);
         repeat (6) smp();
         sample_valid = 0;
         tick();
      end
      // Samples from the very first cycle of ramp mode
      setp(3'h0, 3'h0, 18'h0_0004);
      reg_wr = 1;
      reg_addr = ADDR_PAT_SEL;
      reg_wdata = 8'h48;
      tick();
      reg_wr = 0;
      ca = 3'h2;
      cb = 3'h2;
      repeat (3) smp();
      sample_valid = 0;
      tick();
      // Frame clock source and span
      foreach (fc[j]) begin
         wr(ADDR_FRAME_CLOCK_CTL, fc[j]);
         for (int k = 0; k < 480; k++) begin
            sample_valid = (k % 24 == 0);
            down_conversion_frame = (k % 48 == 0);
            tick();
         end
         chk_len(hi_len, eh[j], "frame high time");
         chk_len(per_len, ep[j], "frame period");
      end
      test_done();
   end
endmodule
